// ==== rtl/cfgld_pkg.sv ====
package cfgld_pkg;

    // Configuration space address of the first configuration byte
    localparam logic [15:0] CFGLD_CFG1_ADDR = 16'hFD00;
    localparam logic [7:0] CFGLD_UNPROG_BYTE = 8'hFF;
    localparam logic [1:0] CFGLD_UNPROG_SEC = 2'h3;

    // Field positions in configuration byte one
    localparam int CFGLD_WDT_EN_POS = 7;
    localparam int CFGLD_RST_DIS_POS = 6;
    localparam int CFGLD_PORT_LVL_POS = 5;
    localparam int CFGLD_BO_SEL_POS = 4;
    localparam int CFGLD_CLK_RATE_POS = 3;
    localparam int CFGLD_OSC_MSB = 2;

    // Security bit positions in the security pair
    localparam int CFGLD_SB1_POS = 0;
    localparam int CFGLD_SB2_POS = 1;

    // Oscillator select codes
    localparam logic [2:0] CFGLD_OSC_EXT = 3'h7;
    localparam logic [2:0] CFGLD_OSC_RC = 3'h3;
    localparam logic [2:0] CFGLD_OSC_LF = 3'h2;
    localparam logic [2:0] CFGLD_OSC_MF = 3'h1;
    localparam logic [2:0] CFGLD_OSC_HF = 3'h0;

    typedef enum logic [2:0] {
        CFGLD_SRC_EXT,
        CFGLD_SRC_RC,
        CFGLD_SRC_LF_XTAL,
        CFGLD_SRC_MF_XTAL,
        CFGLD_SRC_HF_XTAL,
        CFGLD_SRC_RSVD
    } cfgld_osc_src_e;

    // Decoded configuration handed to the rest of the chip
    typedef struct packed {
        logic wdt_en;
        logic rst_pin_en;
        logic port_rst_high;
        logic bo_low_thresh;
        logic clk_rate_opt;
        cfgld_osc_src_e osc_src;
    } cfgld_cfg_s;

    // Code memory access permissions
    typedef struct packed {
        logic prog_ok;
        logic sb2_prog_ok;
        logic verify_ok;
        logic unsupported;
    } cfgld_sec_s;

    // External-data read request and answer
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } cfgld_xrd_req_s;

    typedef struct packed {
        logic hit;
        logic [7:0] data;
    } cfgld_xrd_rsp_s;

endpackage : cfgld_pkg

// ==== rtl/cfgld_sec_decode.sv ====
`timescale 1ns/10ps
module cfgld_sec_decode
    import cfgld_pkg::*;
(
    // Security pair, 0 means programmed
    input wire logic [1:0] sec_bits_i,
    // Permissions
    output cfgld_sec_s sec_o
);
    logic sb1;
    logic sb2;

    assign sb1 = sec_bits_i[CFGLD_SB1_POS];
    assign sb2 = sec_bits_i[CFGLD_SB2_POS];

    always_comb begin
        sec_o = '0;
        if (sb1 && sb2) begin
            sec_o.prog_ok = 1'b1; // [R8]
            sec_o.sb2_prog_ok = 1'b1; // [R8]
            sec_o.verify_ok = 1'b1; // [R8]
        end else if (!sb1 && sb2) begin
            sec_o.sb2_prog_ok = 1'b1; // [R9]
            sec_o.verify_ok = 1'b1; // [R9]
        end else if (sb1 && !sb2) begin
            // Unsupported pair: lock everything down to fail safe
            sec_o.unsupported = 1'b1; // [R10]
        end
        // Both programmed: all fields stay low [R11]
    end

endmodule : cfgld_sec_decode

// ==== rtl/cfgld_config_loader.sv ====
`timescale 1ns/10ps
// Contract
// [R1] Configuration is taken from nonvolatile storage at power-up; software cannot change it.
// [R2] Byte one is readable by the external-data read at its configuration address.
// [R3] Watchdog-enable bit at 0 disables the watchdog; timer stays usable for interrupts.
// [R4] Reset-pin-disable at 1 turns the reset pin into an input-only port pin.
// [R5] Port-reset-level bit picks high (1) or low (0) port state at reset.
// [R6] Brownout select: 1 picks the 2.5V threshold, 0 picks 3.8V.
// [R7] Oscillator field picks external, RC, low, medium or high crystal; others reserved.
// [R8] Both security bits unprogrammed: programming and verify allowed.
// [R9] Only bit one programmed: code programming blocked, bit two programmable, verify allowed.
// [R10] Programmer never programs bit two alone while bit one stays unprogrammed.
// [R11] Both security bits programmed: all verify and programming refused.
// [R12] Unprogrammed bits read 1; decoded values caught during reset, held until next reset. The code captures on the fourth clock edge after reset release.
module cfgld_config_loader
    import cfgld_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Nonvolatile storage contents
    input wire logic [7:0] nv_cfg1_i,
    input wire logic [1:0] nv_sec_i,
    // External-data read port
    input wire cfgld_xrd_req_s xrd_req_i,
    output cfgld_xrd_rsp_s xrd_rsp_o,
    // Decoded configuration
    output cfgld_cfg_s cfg_o,
    output logic wdt_force_off_o,
    output logic rst_pin_as_port_o,
    // Code memory protection
    output cfgld_sec_s sec_o,
    output logic loaded_o
);

    // Three stages for the storage levels, plus a fill marker
    typedef struct packed {
        logic [7:0] cfg1_s1;
        logic [1:0] sec_s1;
        logic [7:0] cfg1_s2;
        logic [1:0] sec_s2;
        logic [7:0] cfg1_s3;
        logic [1:0] sec_s3;
        logic [2:0] fill;
    } cfgld_sync_s;

    // Captured byte, decoded outputs and read answer
    typedef struct packed {
        cfgld_sync_s sync;
        logic [7:0] cfg1;
        logic [1:0] sec;
        logic loaded;
        cfgld_cfg_s cfg;
        logic wdt_off;
        logic rst_port;
        cfgld_sec_s perm;
        cfgld_xrd_rsp_s rsp;
    } cfgld_state_s;

    cfgld_state_s st_ff;
    cfgld_state_s nxt_st;
    cfgld_sec_s sec_dec;
    cfgld_cfg_s cfg_dec;
    logic sync_ready;
    logic sync_stable;
    logic capture;
    logic rd_hit;

    cfgld_sec_decode u_sec_decode (
        .sec_bits_i(st_ff.sec),
        .sec_o(sec_dec)
    );

    function automatic cfgld_osc_src_e osc_decode(input logic [2:0] code);
        cfgld_osc_src_e src;
        // Reserved codes are reported, not mapped to a working source
        case (code)
            CFGLD_OSC_EXT: begin
                src = CFGLD_SRC_EXT; // [R7]
            end
            CFGLD_OSC_RC: begin
                src = CFGLD_SRC_RC; // [R7]
            end
            CFGLD_OSC_LF: begin
                src = CFGLD_SRC_LF_XTAL; // [R7]
            end
            CFGLD_OSC_MF: begin
                src = CFGLD_SRC_MF_XTAL; // [R7]
            end
            CFGLD_OSC_HF: begin
                src = CFGLD_SRC_HF_XTAL; // [R7]
            end
            default: begin
                src = CFGLD_SRC_RSVD; // [R7]
            end
        endcase
        return src;
    endfunction : osc_decode

    // Field decode of the captured byte
    function automatic cfgld_cfg_s cfg_decode(input logic [7:0] raw);
        cfgld_cfg_s dec;
        dec = '0;
        dec.wdt_en = raw[CFGLD_WDT_EN_POS]; // [R3]
        dec.rst_pin_en = ~raw[CFGLD_RST_DIS_POS]; // [R4]
        dec.port_rst_high = raw[CFGLD_PORT_LVL_POS]; // [R5]
        dec.bo_low_thresh = raw[CFGLD_BO_SEL_POS]; // [R6]
        // Passed through raw; the clock divider gives it meaning
        dec.clk_rate_opt = raw[CFGLD_CLK_RATE_POS];
        dec.osc_src = osc_decode(raw[CFGLD_OSC_MSB:0]); // [R7]
        return dec;
    endfunction : cfg_decode

    // Capture waits until the chain is full
    assign sync_ready = st_ff.sync.fill[2];

    // Only the third stage looks at the second, so a moving level is not taken
    assign sync_stable = (st_ff.sync.cfg1_s3 == st_ff.sync.cfg1_s2)
        && (st_ff.sync.sec_s3 == st_ff.sync.sec_s2);
    assign capture = sync_ready && sync_stable && !st_ff.loaded;
    assign cfg_dec = cfg_decode(st_ff.cfg1);
    // Requests before the capture would see the unprogrammed byte, so they are ignored
    assign rd_hit = xrd_req_i.rd
        && st_ff.loaded
        && (xrd_req_i.addr == CFGLD_CFG1_ADDR);

    // Next state; whatever is not named here holds
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp = '0;

        // Synchroniser chain
        nxt_st.sync.cfg1_s1 = nv_cfg1_i;
        nxt_st.sync.sec_s1 = nv_sec_i;
        nxt_st.sync.cfg1_s2 = st_ff.sync.cfg1_s1;
        nxt_st.sync.sec_s2 = st_ff.sync.sec_s1;
        nxt_st.sync.cfg1_s3 = st_ff.sync.cfg1_s2;
        nxt_st.sync.sec_s3 = st_ff.sync.sec_s2;
        nxt_st.sync.fill = {st_ff.sync.fill[1:0], 1'b1};

        // One capture per reset; software has no path to these bits
        if (capture) begin
            nxt_st.cfg1 = st_ff.sync.cfg1_s3; // [R12]
            nxt_st.sec = st_ff.sync.sec_s3; // [R12]
            nxt_st.loaded = 1'b1; // [R1]
        end else begin
            nxt_st.cfg1 = st_ff.cfg1; // [R1]
            nxt_st.sec = st_ff.sec; // [R1]
            nxt_st.loaded = st_ff.loaded;
        end

        // Outputs stay inactive until the byte is final, so no full-access window opens
        if (st_ff.loaded) begin
            nxt_st.cfg.wdt_en = cfg_dec.wdt_en;
            nxt_st.cfg.rst_pin_en = cfg_dec.rst_pin_en;
            nxt_st.cfg.port_rst_high = cfg_dec.port_rst_high;
            nxt_st.cfg.bo_low_thresh = cfg_dec.bo_low_thresh;
            nxt_st.cfg.clk_rate_opt = cfg_dec.clk_rate_opt;
            nxt_st.cfg.osc_src = cfg_dec.osc_src;
            nxt_st.wdt_off = ~cfg_dec.wdt_en; // [R3]
            nxt_st.rst_port = ~cfg_dec.rst_pin_en; // [R4]
            nxt_st.perm = sec_dec; // [R8] [R9] [R11]
        end else begin
            nxt_st.cfg = '0;
            nxt_st.wdt_off = 1'b0;
            nxt_st.rst_port = 1'b0;
            nxt_st.perm = '0;
        end

        // External-data read answer, one cycle
        if (rd_hit) begin
            nxt_st.rsp.hit = 1'b1; // [R2]
            nxt_st.rsp.data = st_ff.cfg1; // [R2]
        end else begin
            nxt_st.rsp.hit = 1'b0;
            nxt_st.rsp.data = '0;
        end
    end

    // Synchronous reset; the whole state is one register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // Chain starts unprogrammed and empty
            st_ff.sync.cfg1_s1 <= CFGLD_UNPROG_BYTE;
            st_ff.sync.sec_s1 <= CFGLD_UNPROG_SEC;
            st_ff.sync.cfg1_s2 <= CFGLD_UNPROG_BYTE;
            st_ff.sync.sec_s2 <= CFGLD_UNPROG_SEC;
            st_ff.sync.cfg1_s3 <= CFGLD_UNPROG_BYTE;
            st_ff.sync.sec_s3 <= CFGLD_UNPROG_SEC;
            st_ff.sync.fill <= '0;

            // Unprogrammed values until the capture
            st_ff.cfg1 <= CFGLD_UNPROG_BYTE; // [R12]
            st_ff.sec <= CFGLD_UNPROG_SEC; // [R12]
            st_ff.loaded <= 1'b0;

            // Decoded outputs inactive
            st_ff.cfg.wdt_en <= 1'b0;
            st_ff.cfg.rst_pin_en <= 1'b0;
            st_ff.cfg.port_rst_high <= 1'b0;
            st_ff.cfg.bo_low_thresh <= 1'b0;
            st_ff.cfg.clk_rate_opt <= 1'b0;
            st_ff.cfg.osc_src <= CFGLD_SRC_EXT;
            st_ff.wdt_off <= 1'b0;
            st_ff.rst_port <= 1'b0;
            // No access before the capture
            st_ff.perm.prog_ok <= 1'b0;
            st_ff.perm.sb2_prog_ok <= 1'b0;
            st_ff.perm.verify_ok <= 1'b0;
            st_ff.perm.unsupported <= 1'b0;
            st_ff.rsp.hit <= 1'b0;
            st_ff.rsp.data <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Every output is a flop of the state
    assign xrd_rsp_o = st_ff.rsp;
    assign cfg_o = st_ff.cfg;
    assign wdt_force_off_o = st_ff.wdt_off;
    assign rst_pin_as_port_o = st_ff.rst_port;
    assign sec_o = st_ff.perm;
    assign loaded_o = st_ff.loaded;

endmodule : cfgld_config_loader

// ==== tb/cfgld_chk.sv ====
`timescale 1ns/10ps
module cfgld_chk
    import cfgld_pkg::*;
(
    // Watched ports
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] nv_cfg1_i,
    input wire logic [1:0] nv_sec_i,
    input wire cfgld_xrd_req_s xrd_req_i,
    input wire cfgld_xrd_rsp_s xrd_rsp_o,
    input wire cfgld_cfg_s cfg_o,
    input wire logic wdt_force_off_o,
    input wire logic rst_pin_as_port_o,
    input wire cfgld_sec_s sec_o,
    input wire logic loaded_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_rd; xrd_req_i.rd && loaded_o; endsequence
    // Capture sees the storage as sampled one edge after release
    property p_wdt; $rose(loaded_o) |=> wdt_force_off_o != $past(nv_cfg1_i[7], 5); endproperty
    a_wdt: assert property (p_wdt) else $error("wdt");
    property p_rpd; $rose(loaded_o) |=> rst_pin_as_port_o == $past(nv_cfg1_i[6], 5); endproperty
    a_rpd: assert property (p_rpd) else $error("rpd");
    property p_prh; $rose(loaded_o) |=> cfg_o.port_rst_high == $past(nv_cfg1_i[5], 5); endproperty
    a_prh: assert property (p_prh) else $error("prh");
    property p_bov; $rose(loaded_o) |=> cfg_o.bo_low_thresh == $past(nv_cfg1_i[4], 5); endproperty
    a_bov: assert property (p_bov) else $error("bov");
    property p_ver; $rose(loaded_o) |=> sec_o.verify_ok == $past(nv_sec_i[1], 5); endproperty
    a_ver: assert property (p_ver) else $error("ver");
    property p_prg; $rose(loaded_o) |=> sec_o.prog_ok == &$past(nv_sec_i, 5); endproperty
    a_prg: assert property (p_prg) else $error("prg");
    property p_hld; loaded_o && $past(loaded_o) |=> $stable(cfg_o) && $stable(sec_o); endproperty
    a_hld: assert property (p_hld) else $error("hld");
    property p_hit; s_rd ##0 xrd_req_i.addr == CFGLD_CFG1_ADDR |=> xrd_rsp_o.hit; endproperty
    a_hit: assert property (p_hit) else $error("hit");
    property p_mis; s_rd ##0 xrd_req_i.addr != CFGLD_CFG1_ADDR |=> xrd_rsp_o == '0; endproperty
    a_mis: assert property (p_mis) else $error("mis");
endmodule : cfgld_chk
bind cfgld_config_loader cfgld_chk i_cfgld_chk (.*);

// ==== tb/cfgld_nvm_model.sv ====
`timescale 1ns/10ps
module cfgld_nvm_model (
    // Programming side
    input wire logic clk_i,
    input wire logic erase_i,
    input wire logic pgm_i,
    input wire logic rogue_i,
    input wire logic [7:0] cfg_i,
    input wire logic [1:0] sec_i,
    // Stored contents
    output logic [7:0] cfg_o,
    output logic [1:0] sec_o
);
    initial {cfg_o, sec_o} = 10'h3FF;
    always @(posedge clk_i) begin
        if (erase_i) begin
            {cfg_o, sec_o} <= 10'h3FF;
        end else if (pgm_i) begin
            cfg_o <= cfg_o & cfg_i;
            // Bit two alone only when a test asks for the bad combination
            if (rogue_i || !(sec_o[0] && sec_i[0])) sec_o <= sec_o & sec_i;
        end
    end
endmodule : cfgld_nvm_model

// ==== tb/tb_cfgld_config_loader.sv ====
`timescale 1ns/10ps
module tb_cfgld_config_loader;
    import cfgld_pkg::*;
    logic clk_i = 0, srst_i = 1, erase = 0, pgm = 0, rogue = 0, rd_q = 0, loaded, wdt_off, rst_port;
    logic [7:0] pcfg = 8'hFF, nv_cfg, b;
    logic [1:0] psec = 2'h3, nv_sec;
    cfgld_xrd_req_s req = '0;
    cfgld_xrd_rsp_s rsp;
    cfgld_cfg_s cfg;
    cfgld_sec_s sec;
    int fails = 0, num_checks = 0, t;
    logic [8:0] expq[$];
    logic [2:0] oc[8] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4, 3'h5, 3'h6};
    logic [1:0] sc[4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    logic [3:0] se[4] = '{4'hE, 4'h6, 4'h0, 4'h1};
    cfgld_nvm_model i_cfgld_nvm_model (.clk_i, .erase_i(erase), .pgm_i(pgm), .rogue_i(rogue),
        .cfg_i(pcfg), .sec_i(psec), .cfg_o(nv_cfg), .sec_o(nv_sec));
    cfgld_config_loader i_cfgld_config_loader (.clk_i, .srst_i, .nv_cfg1_i(nv_cfg), .nv_sec_i(nv_sec),
        .xrd_req_i(req), .xrd_rsp_o(rsp), .cfg_o(cfg), .wdt_force_off_o(wdt_off), .rst_pin_as_port_o(rst_port),
        .sec_o(sec), .loaded_o(loaded));
    initial forever #2 clk_i = ~clk_i;
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // Held request, so consecutive calls give back-to-back reads
    task rd(input logic [15:0] a, input logic [8:0] e);
        req = {1'b1, a};
        expq.push_back(e);
        @(negedge clk_i);
    endtask : rd
    always @(posedge clk_i) begin
        if (rd_q) chk("xrd", expq.pop_front(), rsp);
        rd_q <= req.rd && loaded;
    end
    initial begin
        void'($urandom(83012));
        for (int k = 0; k < 8; k++) begin
            b = {5'($urandom), oc[k]};
            @(negedge clk_i) erase = 1;
            @(negedge clk_i) erase = 0;
            {pcfg, psec, rogue, pgm} = {b, sc[k % 4], k % 4 == 3, 1'b1};
            @(negedge clk_i) pgm = 0;
            srst_i = 1;
            repeat (2) @(negedge clk_i);
            srst_i = 0;
            for (t = 0; t < 10 && loaded !== 1'b1; t++) @(negedge clk_i);
            if (t == 10) begin
                fails++;
                break;
            end
            rd(CFGLD_CFG1_ADDR, {1'b1, b});
            rd(16'($urandom_range(16'hFC00, 16'hFCFF)), 9'h0);
            {pcfg, pgm} = 9'h1;
            rd(CFGLD_CFG1_ADDR, {1'b1, b});
            {req.rd, pgm} = 2'h0;
            repeat (2) @(negedge clk_i);
            chk("cfg", {b[7], !b[6], b[5:3], k < 5 ? 3'(k) : 3'(CFGLD_SRC_RSVD)}, cfg);
            chk("sec", se[k % 4], sec);
            chk("wdt", !b[7], wdt_off);
            chk("rpd", b[6], rst_port);
            $display("test %0d done", k);
        end
        results();
    end
endmodule : tb_cfgld_config_loader
